// ==== hw/mode_select_pkg.sv ====
// shared constants and types for the network master mode-select block
package mode_select_pkg;
  // switch positions, switch 1 at bit 0
  localparam int SW_RATE_LO = 0;
  localparam int SW_RATE_HI = 1;
  localparam int SW_POINT = 2;
  localparam int SW_SPARE4 = 3;
  localparam int SW_SPARE5 = 4;
  localparam int SW_MODE_A = 5;
  localparam int SW_MODE_B = 6;
  localparam int SW_SPARE8 = 7;
  // cycles to let the pin synchroniser fill before the one-time sample
  localparam logic [1:0] SAMPLE_DELAY = 2'h2;

  // apb byte addresses
  localparam logic [7:0] ADDR_SETTINGS = 8'h00;
  localparam logic [7:0] ADDR_PARAM = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;

  // status word fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ERR_BIT = 1;
  localparam int ST_DONE_BIT = 4;
  // command word fields
  localparam int CMD_START_BIT = 0;
  // settings / param word fields
  localparam int F_RATE_LSB = 0;
  localparam int F_POINT_BIT = 2;
  localparam int F_MODE_LSB = 3;
  localparam int F_VARIANT_BIT = 5;
  localparam int F_SPARE_BIT = 6;
  localparam int F_RAW_LSB = 8;
  localparam logic [4:0] PARAM_RESET = 5'h00;

  typedef enum logic [1:0] {
    RATE_156K = 2'b00,
    RATE_625K = 2'b01,
    RATE_2M5 = 2'b10,
    RATE_BAD = 2'b11
  } rate_t;

  typedef enum logic [1:0] {
    MODE_ONLINE = 2'b00,
    MODE_CONFIG = 2'b01,
    MODE_TEST = 2'b10,
    MODE_BAD = 2'b11
  } op_mode_t;

  typedef struct packed {
    rate_t rate;
    logic point_width_select;
    op_mode_t op_mode;
  } settings_t;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_RUN = 2'b01,
    ST_COLLECT = 2'b10,
    ST_DONE = 2'b11
  } state_t;
endpackage

// ==== hw/network_master_mode_select.sv ====
// startup mode decode and station collection control for a field-network master
// Contract
// - rate switches: off/off 156k, on/off 625k, off/on 2.5M; both on prohibited
// - third switch on selects sixteen-point mode, off selects four-point mode
// - switches six/seven: off/off online, on/off auto config, off/on test
// - auto config sets status word 28 bit four once all stations are gathered
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module network_master_mode_select (
  input wire logic clock, // 250 MHz
  input wire logic rst_n, // async power-on reset
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic [7:0] dip_sw, // switch pins, switch 1 at bit 0, high = on
  input wire logic param_variant, // strap: settings come from parameters
  input wire logic station_seen, // pulse: one station's info collected
  input wire logic station_last, // with station_seen: it was the last one
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output mode_select_pkg::settings_t settings, // decoded active settings
  output logic setting_error, // prohibited rate or mode selected
  output logic collect_start, // pulse: network engine starts collection
  output logic config_done // collection finished
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic mode_select_pkg::settings_t decode_sw(input logic [7:0] sw);
    mode_select_pkg::settings_t s;
    s.rate = mode_select_pkg::rate_t'({sw[mode_select_pkg::SW_RATE_HI],
                                       sw[mode_select_pkg::SW_RATE_LO]});
    s.point_width_select = sw[mode_select_pkg::SW_POINT];
    s.op_mode = mode_select_pkg::op_mode_t'({sw[mode_select_pkg::SW_MODE_B],
                                             sw[mode_select_pkg::SW_MODE_A]});
    return s;
  endfunction

  function automatic logic bad_setting(input mode_select_pkg::settings_t s);
    return (s.rate == mode_select_pkg::RATE_BAD) || (s.op_mode == mode_select_pkg::MODE_BAD);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser and one-time sample
  logic [7:0] sw_meta_reg;
  logic [7:0] sw_sync_reg;
  logic var_meta_reg;
  logic var_sync_reg;
  logic [7:0] sw_lat_reg;
  logic [7:0] sw_lat_next;
  logic var_lat_reg;
  logic var_lat_next;
  logic [1:0] samp_cnt_reg;
  logic [1:0] samp_cnt_next;
  mode_select_pkg::state_t state_reg;
  mode_select_pkg::state_t state_next;
  logic done_reg;
  logic done_next;
  logic start_reg;
  logic start_next;
  logic [4:0] param_reg;
  logic [4:0] param_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  logic wr_acc;
  logic setup;
  logic addr_ok;
  logic cmd_start;
  logic spare_on;
  mode_select_pkg::settings_t sw_set;
  mode_select_pkg::settings_t eff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sw_meta_reg <= 8'h00;
      sw_sync_reg <= 8'h00;
      var_meta_reg <= 1'b0;
      var_sync_reg <= 1'b0;
    end else if (ce) begin
      sw_meta_reg <= dip_sw;
      sw_sync_reg <= sw_meta_reg;
      var_meta_reg <= param_variant;
      var_sync_reg <= var_meta_reg;
    end
  end

  // settings are caught once, after the synchroniser has filled
  always_comb begin
    samp_cnt_next = samp_cnt_reg;
    sw_lat_next = sw_lat_reg;
    var_lat_next = var_lat_reg;
    if (state_reg == mode_select_pkg::ST_WAIT) begin
      if (samp_cnt_reg == mode_select_pkg::SAMPLE_DELAY) begin
        sw_lat_next = sw_sync_reg;
        var_lat_next = var_sync_reg;
      end else begin
        samp_cnt_next = samp_cnt_reg + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode
  assign sw_set = decode_sw(sw_lat_reg);
  // the parameter variant ignores the switches and uses the software word
  assign eff = var_lat_reg ? mode_select_pkg::settings_t'(param_reg) : sw_set;
  // spare switches have no function; only reported so software can warn
  assign spare_on = sw_lat_reg[mode_select_pkg::SW_SPARE4] |
                    sw_lat_reg[mode_select_pkg::SW_SPARE5] |
                    sw_lat_reg[mode_select_pkg::SW_SPARE8];

  assign settings = eff;
  assign setting_error = (state_reg != mode_select_pkg::ST_WAIT) && bad_setting(eff);
  assign collect_start = start_reg;
  assign config_done = done_reg;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign addr_ok = (paddr == mode_select_pkg::ADDR_SETTINGS) ||
                   (paddr == mode_select_pkg::ADDR_PARAM) ||
                   (paddr == mode_select_pkg::ADDR_CMD) ||
                   (paddr == mode_select_pkg::ADDR_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = rdata_reg;
  assign cmd_start = wr_acc && (paddr == mode_select_pkg::ADDR_CMD) &&
                     pwdata[mode_select_pkg::CMD_START_BIT];

  always_comb begin
    param_next = param_reg;
    rdata_next = rdata_reg;
    if (wr_acc && (paddr == mode_select_pkg::ADDR_PARAM)) begin
      param_next = pwdata[4:0];
    end
    if (setup && !pwrite) begin
      rdata_next = 32'h0000_0000;
      unique case (paddr)
        mode_select_pkg::ADDR_SETTINGS: begin
          rdata_next[4:0] = eff;
          rdata_next[mode_select_pkg::F_VARIANT_BIT] = var_lat_reg;
          rdata_next[mode_select_pkg::F_SPARE_BIT] = spare_on;
          rdata_next[mode_select_pkg::F_RAW_LSB +: 8] = sw_lat_reg;
        end
        mode_select_pkg::ADDR_PARAM: begin
          rdata_next[4:0] = param_reg;
        end
        mode_select_pkg::ADDR_STATUS: begin
          rdata_next[mode_select_pkg::ST_BUSY_BIT] = (state_reg == mode_select_pkg::ST_COLLECT);
          rdata_next[mode_select_pkg::ST_ERR_BIT] = setting_error;
          rdata_next[mode_select_pkg::ST_DONE_BIT] = done_reg;
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // collection control
  always_comb begin
    state_next = state_reg;
    done_next = done_reg;
    start_next = 1'b0;
    unique case (state_reg)
      mode_select_pkg::ST_WAIT: begin
        if (samp_cnt_reg == mode_select_pkg::SAMPLE_DELAY) begin
          state_next = mode_select_pkg::ST_RUN;
        end
      end
      mode_select_pkg::ST_RUN: begin
        if ((eff.op_mode == mode_select_pkg::MODE_CONFIG) && !bad_setting(eff)) begin
          // switch build starts by itself; parameter build waits for software
          if (!var_lat_reg || cmd_start) begin
            state_next = mode_select_pkg::ST_COLLECT;
            start_next = 1'b1;
          end
        end
      end
      mode_select_pkg::ST_COLLECT: begin
        if (station_seen && station_last) begin
          state_next = mode_select_pkg::ST_DONE;
          done_next = 1'b1;
        end
      end
      mode_select_pkg::ST_DONE: begin
        // done holds until the next power-on reset
        state_next = mode_select_pkg::ST_DONE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= mode_select_pkg::ST_WAIT;
      samp_cnt_reg <= 2'h0;
      sw_lat_reg <= 8'h00;
      var_lat_reg <= 1'b0;
      done_reg <= 1'b0;
      start_reg <= 1'b0;
      param_reg <= mode_select_pkg::PARAM_RESET;
      rdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      state_reg <= state_next;
      samp_cnt_reg <= samp_cnt_next;
      sw_lat_reg <= sw_lat_next;
      var_lat_reg <= var_lat_next;
      done_reg <= done_next;
      start_reg <= start_next;
      param_reg <= param_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_rate_map;
    @(posedge clock) disable iff (!rst_n)
      !var_lat_reg |->
        (settings.rate == mode_select_pkg::RATE_156K) ==
          (!sw_lat_reg[mode_select_pkg::SW_RATE_LO] && !sw_lat_reg[mode_select_pkg::SW_RATE_HI]) &&
        (settings.rate == mode_select_pkg::RATE_625K) ==
          (sw_lat_reg[mode_select_pkg::SW_RATE_LO] && !sw_lat_reg[mode_select_pkg::SW_RATE_HI]) &&
        (settings.rate == mode_select_pkg::RATE_2M5) ==
          (!sw_lat_reg[mode_select_pkg::SW_RATE_LO] && sw_lat_reg[mode_select_pkg::SW_RATE_HI]);
  endproperty
  a_rate_map: assert property (p_rate_map) else $error("rate decode wrong");

  property p_bad_rate;
    @(posedge clock) disable iff (!rst_n)
      (state_reg != mode_select_pkg::ST_WAIT) && (settings.rate == mode_select_pkg::RATE_BAD)
        |-> setting_error && (state_reg != mode_select_pkg::ST_COLLECT);
  endproperty
  a_bad_rate: assert property (p_bad_rate) else $error("prohibited rate not flagged");

  property p_point_map;
    @(posedge clock) disable iff (!rst_n)
      !var_lat_reg |-> settings.point_width_select == sw_lat_reg[mode_select_pkg::SW_POINT];
  endproperty
  a_point_map: assert property (p_point_map) else $error("point mode decode wrong");

  property p_auto_start;
    @(posedge clock) disable iff (!rst_n)
      ce && (state_reg == mode_select_pkg::ST_RUN) && !var_lat_reg && !setting_error &&
      sw_lat_reg[mode_select_pkg::SW_MODE_A] && !sw_lat_reg[mode_select_pkg::SW_MODE_B]
        |=> collect_start && (state_reg == mode_select_pkg::ST_COLLECT);
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("config mode did not start");

  property p_no_start_other;
    @(posedge clock) disable iff (!rst_n)
      collect_start |-> $past(settings.op_mode) == mode_select_pkg::MODE_CONFIG;
  endproperty
  a_no_start_other: assert property (p_no_start_other) else $error("start outside config");

  property p_done_set;
    @(posedge clock) disable iff (!rst_n)
      ce && (state_reg == mode_select_pkg::ST_COLLECT) && station_seen && station_last
        |=> config_done ##1 config_done;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done bit not set");

  property p_cmd_start;
    @(posedge clock) disable iff (!rst_n)
      $rose(collect_start) && var_lat_reg |-> $past(cmd_start);
  endproperty
  a_cmd_start: assert property (p_cmd_start) else $error("variant started without command");

  property p_sample_once;
    @(posedge clock) disable iff (!rst_n)
      (state_reg != mode_select_pkg::ST_WAIT) |=> $stable(sw_lat_reg) && $stable(var_lat_reg);
  endproperty
  a_sample_once: assert property (p_sample_once) else $error("settings resampled");

  property p_wait_quiet;
    @(posedge clock) disable iff (!rst_n)
      (state_reg == mode_select_pkg::ST_WAIT) |-> !setting_error && !collect_start;
  endproperty
  a_wait_quiet: assert property (p_wait_quiet) else $error("acting before settings sampled");

  property p_mode_idle;
    @(posedge clock) disable iff (!rst_n)
      (state_reg == mode_select_pkg::ST_RUN) &&
      (settings.op_mode != mode_select_pkg::MODE_CONFIG)
        |=> !collect_start;
  endproperty
  a_mode_idle: assert property (p_mode_idle) else $error("start outside config mode");

  property p_done_hold;
    @(posedge clock) disable iff (!rst_n)
      config_done |=> config_done;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done bit dropped");

  property p_status_done;
    @(posedge clock) disable iff (!rst_n)
      ce && psel && !penable && !pwrite && (paddr == mode_select_pkg::ADDR_STATUS)
        |=> prdata[mode_select_pkg::ST_DONE_BIT] == $past(config_done);
  endproperty
  a_status_done: assert property (p_status_done) else $error("status done bit wrong");

endmodule

// ==== dv/station_model.sv ====
// remote station model: answers a collection with a train of station pulses
`timescale 1ns/1ns
module station_model (
  input wire logic clock, // system clock
  input wire logic rst_n, // async reset
  input wire logic collect_start, // collection begins
  input wire logic [3:0] stations, // stations on the network, at least one
  input wire logic [3:0] gap, // idle cycles between stations
  output logic station_seen, // one station gathered
  output logic station_last // qualifies station_seen
);
  logic [3:0] left;
  logic [3:0] wait_cnt;
  logic active;
  // qualifier toggles when unqualified, except in a collect_start cycle where it holds, so a stale level is never trusted
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      active <= 1'b0;
      left <= 4'h0;
      wait_cnt <= 4'h0;
      station_seen <= 1'b0;
      station_last <= 1'b0;
    end else if (collect_start) begin
      active <= 1'b1;
      left <= stations;
      wait_cnt <= gap;
      station_seen <= 1'b0;
    end else if (active && wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
      station_seen <= 1'b0;
      station_last <= ~station_last;
    end else if (active) begin
      station_seen <= 1'b1;
      station_last <= (left == 4'h1);
      left <= left - 4'h1;
      wait_cnt <= gap;
      active <= (left != 4'h1);
    end else begin
      station_seen <= 1'b0;
      station_last <= ~station_last;
    end
  end
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for the mode-select block
`timescale 1ns/1ns
module tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] dip_sw = 8'h00;
  logic param_variant = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] stations = 4'h2;
  logic [3:0] gap = 4'h1;
  logic station_seen, station_last, pready, pslverr, setting_error, collect_start, config_done;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic err;
  mode_select_pkg::settings_t settings;
  int failures = 0;
  int compares = 0;
  int starts = 0;
  int seen = 0;
  always #2 clock = ~clock;
  network_master_mode_select network_master_mode_select_inst (.clock(clock), .rst_n(rst_n),
    .ce(ce), .dip_sw(dip_sw), .param_variant(param_variant), .station_seen(station_seen),
    .station_last(station_last), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .settings(settings), .setting_error(setting_error), .collect_start(collect_start),
    .config_done(config_done));
  station_model station_model_inst (.clock(clock), .rst_n(rst_n), .collect_start(collect_start),
    .stations(stations), .gap(gap), .station_seen(station_seen), .station_last(station_last));
  always @(posedge clock) begin
    if (!rst_n) begin
      starts <= 0;
      seen <= 0;
    end else begin
      if (collect_start === 1'b1) starts <= starts + 1;
      if (station_seen === 1'b1) seen <= seen + 1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // power cycle: settings are only sampled on the way out of reset
  task automatic power_up(input logic [7:0] sw, input logic v);
    @(posedge clock);
    rst_n <= 1'b0;
    dip_sw <= sw;
    param_variant <= v;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (10) @(posedge clock);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (config_done !== 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    if (config_done !== 1'b1) begin
      failures++;
      wrap_up();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic decode_table();
    logic [4:0] k;
    logic e;
    for (int i = 0; i < 32; i++) begin
      k = i[4:0];
      e = (k[1:0] == 2'b11) || (k[4:3] == 2'b11);
      power_up({1'b0, k[4], k[3], 2'b00, k[2], k[1], k[0]}, 1'b0);
      chk({27'h0, settings}, {27'h0, k[1:0], k[2], k[4:3]});
      chk({31'h0, setting_error}, {31'h0, e});
      chk(starts, {31'h0, k[4:3] == 2'b01 && !e});
    end
  endtask
  task automatic switch_config();
    stations <= 4'h3;
    gap <= 4'h4;
    power_up(8'h2a, 1'b0);
    dip_sw <= 8'h01;
    repeat (5) @(posedge clock);
    chk({27'h0, settings}, 32'h11);
    apb(1'b0, mode_select_pkg::ADDR_SETTINGS, 32'h0);
    chk(rd, 32'h2a51);
    wait_done();
    chk(seen, 3);
    apb(1'b1, mode_select_pkg::ADDR_STATUS, 32'h0);
    apb(1'b0, mode_select_pkg::ADDR_STATUS, 32'h0);
    chk(rd & 32'h13, 32'h10);
  endtask
  task automatic param_variant_run();
    stations <= 4'h2;
    gap <= 4'h0;
    power_up(8'h00, 1'b1);
    apb(1'b0, mode_select_pkg::ADDR_PARAM, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, mode_select_pkg::ADDR_PARAM, 32'h11);
    apb(1'b0, mode_select_pkg::ADDR_PARAM, 32'h0);
    chk(rd, 32'h11);
    chk({27'h0, settings}, 32'h11);
    repeat (10) @(posedge clock);
    chk(starts, 0);
    chk({31'h0, config_done}, 32'h0);
    apb(1'b1, mode_select_pkg::ADDR_CMD, 32'h1);
    wait_done();
    chk(starts, 1);
    apb(1'b0, 8'h40, 32'h0);
    chk({rd[30:0], err}, 32'h1);
  endtask
  // clock enable low after power-up: nothing may be sampled or started
  task automatic freeze_run();
    ce <= 1'b0;
    power_up(8'h21, 1'b0);
    chk({27'h0, settings}, 32'h0);
    chk(starts, 0);
    ce <= 1'b1;
    repeat (10) @(posedge clock);
    chk({27'h0, settings}, 32'h09);
    chk(starts, 1);
  endtask
  initial begin
    #200000;
    failures++;
    wrap_up();
  end
  initial begin
    decode_table();
    switch_config();
    param_variant_run();
    freeze_run();
    wrap_up();
  end
endmodule
